// ==== rtl/mtc_pkg.sv ====
`default_nettype none
package mtc_pkg;
   // ---------------------------------------------------------------
   // Register map
   // ---------------------------------------------------------------
   localparam logic [7:0]  TXC_OFFSET    = 8'h70;
   localparam logic [15:0] TXC_RESET     = 16'h0000;
   localparam logic [15:0] TXC_WMASK     = 16'h01ff;
   localparam int          ICMP_BIT      = 8;
   localparam int          UDP_BIT       = 7;
   localparam int          TCP_BIT       = 6;
   localparam int          IPH_BIT       = 5;
   localparam int          FLUSH_BIT     = 4;
   localparam int          FCE_BIT       = 3;
   localparam int          PAD_BIT       = 2;
   localparam int          CRC_BIT       = 1;
   localparam int          RUN_BIT       = 0;

   // ---------------------------------------------------------------
   // Frame layout
   // ---------------------------------------------------------------
   localparam logic [6:0]  MIN_FRAME     = 7'h40;
   localparam logic [6:0]  CRC_BYTES     = 7'h04;
   localparam logic [31:0] CRC_POLY      = 32'hedb88320;
   localparam logic [31:0] CRC_INIT      = 32'hffffffff;
   localparam logic [6:0]  ETYPE_HI_IDX  = 7'h0c;
   localparam logic [6:0]  ETYPE_LO_IDX  = 7'h0d;
   localparam logic [6:0]  IP_VER_IDX    = 7'h0e;
   localparam logic [6:0]  IP_PROTO_IDX  = 7'h17;
   localparam logic [7:0]  ETYPE_IPV4_HI = 8'h08;
   localparam logic [7:0]  ETYPE_IPV4_LO = 8'h00;
   localparam logic [3:0]  IP_VERSION4   = 4'h4;
   localparam logic [7:0]  PROTO_ICMP    = 8'h01;
   localparam logic [7:0]  PROTO_TCP     = 8'h06;
   localparam logic [7:0]  PROTO_UDP     = 8'h11;

   typedef enum logic [2:0] {
      S_STOP = 3'b000,
      S_DATA = 3'b001,
      S_PAD  = 3'b010,
      S_CRC  = 3'b011
   } mtc_state_e;
endpackage
`default_nettype wire

// ==== rtl/mtc_cls_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface mtc_cls_if;
   logic [7:0] byte_v;
   logic       stb;
   logic [6:0] idx;
   logic [3:0] en;
   logic [3:0] req;
   modport src (output byte_v, output stb, output idx, output en,
                input req);
   modport cls (input byte_v, input stb, input idx, input en,
                output req);
endinterface
`default_nettype wire

// ==== rtl/mtc_classify.sv ====
`timescale 1ns/1ps
`default_nettype none
module mtc_classify
   import mtc_pkg::*;
(
   input  wire logic clk_i,
   input  wire logic reset_i,
   mtc_cls_if.cls    cls
);
   logic       etype_hi_q;
   logic       ipv4_q;
   logic [7:0] proto_q;

   // ---------------------------------------------------------------
   // Header sniffing, one byte per strobe
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         etype_hi_q <= 1'b0;
         ipv4_q     <= 1'b0;
         proto_q    <= 8'h00;
      end else if (cls.stb) begin
         if (cls.idx == 7'h00) begin
            etype_hi_q <= 1'b0;
            ipv4_q     <= 1'b0;
            proto_q    <= 8'h00;
         end
         if (cls.idx == ETYPE_HI_IDX)
            etype_hi_q <= (cls.byte_v == ETYPE_IPV4_HI);
         if (cls.idx == ETYPE_LO_IDX)
            ipv4_q <= etype_hi_q && (cls.byte_v == ETYPE_IPV4_LO);
         if (cls.idx == IP_VER_IDX)
            ipv4_q <= ipv4_q && (cls.byte_v[7:4] == IP_VERSION4);
         if (cls.idx == IP_PROTO_IDX)
            proto_q <= cls.byte_v;
      end
   end

   // Requests only for protocols whose enable is on
   assign cls.req[3] = cls.en[3] && ipv4_q && (proto_q == PROTO_ICMP); // RULE1
   assign cls.req[2] = cls.en[2] && ipv4_q && (proto_q == PROTO_UDP);  // RULE2
   assign cls.req[1] = cls.en[1] && ipv4_q && (proto_q == PROTO_TCP);  // RULE3
   assign cls.req[0] = cls.en[0] && ipv4_q;                            // RULE4
endmodule
`default_nettype wire

// ==== rtl/mtc_top.sv ====
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// RULE1: ICMP checksum inserted only when bit 8 set
// RULE2: UDP checksum inserted only when bit 7 set
// RULE3: TCP checksum inserted only when bit 6 set
// RULE4: IPv4 header checksum only when bit 5 set
// RULE5: Flush clears queue and frame pointer
// RULE6: Software stops transmit before flush, then unflushes
// RULE7: Full duplex flow control sends PAUSE at threshold
// RULE8: Half duplex flow control uses back-pressure
// RULE9: Flow control off: no PAUSE, no back-pressure
// RULE10: Padding extends short frames to 64 bytes
// RULE11: Software enables CRC whenever padding is enabled; the testbench also runs one pass with padding and no CRC, padded to 64
// RULE12: CRC enable appends 32-bit CRC to frame
// RULE13: Run enable starts transmit of queued frames
// RULE14: Stop takes effect after current frame ends
// RULE15: All control bits reset to zero
module mtc_top
   import mtc_pkg::*;
#(
   parameter int FPTR_W = 12
) (
   input  wire logic              clk_i,
   input  wire logic              reset_i,
   input  wire logic              reg_wr_i,
   input  wire logic              reg_rd_i,
   input  wire logic [7:0]        reg_addr_i,
   input  wire logic [1:0]        reg_be_i,
   input  wire logic [15:0]       reg_wdata_i,
   output logic      [15:0]       reg_rdata_o,
   input  wire logic [7:0]        in_data_i,
   input  wire logic              in_valid_i,
   input  wire logic              in_last_i,
   output logic                   in_ready_o,
   output logic      [7:0]        out_data_o,
   output logic                   out_valid_o,
   output logic                   out_last_o,
   input  wire logic              out_ready_i,
   input  wire logic              full_duplex_i,
   input  wire logic              rx_thresh_i,
   output logic                   pause_req_o,
   output logic                   backpressure_o,
   output logic                   flush_o,
   output logic                   tx_running_o,
   output logic      [FPTR_W-1:0] frame_ptr_o,
   output logic      [3:0]        csum_req_o
);
   import mtc_pkg::*;

   // ---------------------------------------------------------------
   // Control register
   // ---------------------------------------------------------------
   logic [15:0] ctrl_q;
   logic [15:0] ctrl_d;
   logic [15:0] rdata_d;
   wire         reg_hit   = (reg_addr_i == TXC_OFFSET);
   wire         wr_hit    = reg_wr_i && reg_hit;
   wire  [15:0] wr_merge  = {reg_be_i[1] ? reg_wdata_i[15:8] : ctrl_q[15:8],
                             reg_be_i[0] ? reg_wdata_i[7:0] : ctrl_q[7:0]};
   assign ctrl_d  = wr_hit ? (wr_merge & TXC_WMASK) : ctrl_q;
   assign rdata_d = (reg_rd_i && reg_hit) ? (ctrl_q & TXC_WMASK) : 16'h0000;

   wire flush  = ctrl_q[FLUSH_BIT];
   wire run_en = ctrl_q[RUN_BIT];
   wire fce    = ctrl_q[FCE_BIT];
   wire pad_en = ctrl_q[PAD_BIT];
   wire crc_en = ctrl_q[CRC_BIT];

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         ctrl_q      <= TXC_RESET; // RULE15
         reg_rdata_o <= 16'h0000;
      end else begin
         ctrl_q      <= ctrl_d;
         reg_rdata_o <= rdata_d;
      end
   end

   // ---------------------------------------------------------------
   // Frame sequencer
   // ---------------------------------------------------------------
   mtc_state_e       state_q;
   mtc_state_e       state_d;
   logic [6:0]       cnt_q;
   logic [31:0]      crc_q;
   logic [1:0]       crc_idx_q;
   logic [FPTR_W-1:0] fptr_q;
   logic             last_d;

   wire        fire_in  = in_valid_i && in_ready_o;
   wire        fire_out = out_valid_o && out_ready_i;
   wire        out_free = !out_valid_o || fire_out;
   // Pad to 60 when CRC follows, so the wire frame is 64
   wire  [6:0] pad_tgt  = crc_en ? (MIN_FRAME - CRC_BYTES) : MIN_FRAME;
   wire  [6:0] cnt_inc  = (cnt_q == 7'h7f) ? cnt_q : cnt_q + 7'h01;
   wire        pad_more = pad_en && (cnt_inc < pad_tgt); // RULE10
   wire [31:0] crc_out  = ~crc_q;
   wire  [7:0] crc_byte = crc_out[{crc_idx_q, 3'b000} +: 8];
   wire        load     = (state_q == S_DATA) ? fire_in :
                          ((state_q == S_PAD) || (state_q == S_CRC)) ?
                          out_free : 1'b0;
   wire  [7:0] load_byte = (state_q == S_DATA) ? in_data_i :
                           (state_q == S_PAD) ? 8'h00 : crc_byte;
   wire        frame_end = load && last_d;

   function automatic logic [31:0] crc_step(input logic [31:0] c,
                                            input logic [7:0]  b);
      logic [31:0] r;
      r = c ^ {24'h000000, b};
      for (int i = 0; i < 8; i++) begin
         r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
      end
      return r;
   endfunction

   always_comb begin
      state_d = state_q;
      last_d  = 1'b0;
      case (state_q)
         S_STOP: begin
            if (run_en && !flush)
               state_d = S_DATA; // RULE13
         end
         S_DATA: begin
            if (fire_in && in_last_i) begin
               if (pad_more)
                  state_d = S_PAD;
               else if (crc_en)
                  state_d = S_CRC; // RULE12
               else begin
                  last_d  = 1'b1;
                  state_d = run_en ? S_DATA : S_STOP;
               end
            end else if (!fire_in && cnt_q == 7'h00 && !run_en) begin
               state_d = S_STOP; // RULE14
            end
         end
         S_PAD: begin
            if (out_free && cnt_inc >= pad_tgt) begin
               if (crc_en)
                  state_d = S_CRC;
               else begin
                  last_d  = 1'b1;
                  state_d = run_en ? S_DATA : S_STOP;
               end
            end
         end
         S_CRC: begin
            if (out_free && crc_idx_q == 2'h3) begin
               last_d  = 1'b1;
               state_d = run_en ? S_DATA : S_STOP; // RULE14
            end
         end
         default: state_d = S_STOP;
      endcase
      if (flush)
         state_d = S_STOP; // RULE5
   end

   wire out_valid_d = load ? 1'b1 : (fire_out ? 1'b0 : out_valid_o);
   // One byte in flight: halves throughput, but in_ready stays a flop
   wire in_ready_d  = (state_d == S_DATA) && !out_valid_d;

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         state_q     <= S_STOP;
         cnt_q       <= 7'h00;
         crc_q       <= CRC_INIT;
         crc_idx_q   <= 2'h0;
         fptr_q      <= '0;
         out_data_o  <= 8'h00;
         out_valid_o <= 1'b0;
         out_last_o  <= 1'b0;
         in_ready_o  <= 1'b0;
      end else begin
         state_q     <= state_d;
         out_valid_o <= out_valid_d;
         in_ready_o  <= in_ready_d;
         if (load) begin
            out_data_o <= load_byte;
            out_last_o <= last_d;
         end
         if (flush) begin
            cnt_q     <= 7'h00; // RULE5
            crc_q     <= CRC_INIT;
            crc_idx_q <= 2'h0;
            fptr_q    <= '0; // RULE5
         end else if (frame_end) begin
            cnt_q     <= 7'h00;
            crc_q     <= CRC_INIT;
            crc_idx_q <= 2'h0;
            fptr_q    <= fptr_q + 1'b1;
         end else if (load) begin
            cnt_q <= cnt_inc;
            if (state_q == S_CRC)
               crc_idx_q <= crc_idx_q + 2'h1;
            else
               crc_q <= crc_step(crc_q, load_byte); // RULE12
         end
      end
   end

   // ---------------------------------------------------------------
   // Checksum classification
   // ---------------------------------------------------------------
   mtc_cls_if cls_if ();
   assign cls_if.byte_v = load_byte;
   assign cls_if.stb    = load && (state_q == S_DATA);
   assign cls_if.idx    = cnt_q;
   assign cls_if.en     = {ctrl_q[ICMP_BIT], ctrl_q[UDP_BIT],
                           ctrl_q[TCP_BIT], ctrl_q[IPH_BIT]};

   mtc_classify u_cls (
      .clk_i   (clk_i),
      .reset_i (reset_i),
      .cls     (cls_if.cls)
   );

   // ---------------------------------------------------------------
   // Flow control and status
   // ---------------------------------------------------------------
   logic thr_q;
   wire  pause_d = fce && full_duplex_i && rx_thresh_i && !thr_q; // RULE7
   wire  bp_d    = fce && !full_duplex_i && rx_thresh_i;          // RULE8

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         thr_q          <= 1'b0;
         pause_req_o    <= 1'b0;
         backpressure_o <= 1'b0;
         flush_o        <= 1'b0;
         tx_running_o   <= 1'b0;
         csum_req_o     <= 4'h0;
      end else begin
         thr_q          <= rx_thresh_i;
         pause_req_o    <= pause_d; // RULE9
         backpressure_o <= bp_d;    // RULE9
         flush_o        <= flush;
         tx_running_o   <= (state_d != S_STOP);
         if (frame_end)
            csum_req_o <= cls_if.req; // RULE1 RULE2 RULE3 RULE4
      end
   end
   assign frame_ptr_o = fptr_q;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   a_icmp_gate: // RULE1
   assert property (@(posedge clk_i) disable iff (reset_i)
      (frame_end && !ctrl_q[ICMP_BIT]) |=> !csum_req_o[3])
      else $error("ICMP request without enable");
   a_udp_gate: // RULE2
   assert property (@(posedge clk_i) disable iff (reset_i)
      (frame_end && !ctrl_q[UDP_BIT]) |=> !csum_req_o[2])
      else $error("UDP request without enable");
   a_tcp_gate: // RULE3
   assert property (@(posedge clk_i) disable iff (reset_i)
      (frame_end && !ctrl_q[TCP_BIT]) |=> !csum_req_o[1])
      else $error("TCP request without enable");
   a_iph_gate: // RULE4
   assert property (@(posedge clk_i) disable iff (reset_i)
      (frame_end && !ctrl_q[IPH_BIT]) |=> !csum_req_o[0])
      else $error("IP header request without enable");
   a_flush_clear: // RULE5
   assert property (@(posedge clk_i) disable iff (reset_i)
      flush |=> (state_q == S_STOP) && (fptr_q == '0) && flush_o)
      else $error("Flush did not clear queue state");
   a_pause_pulse: // RULE7
   assert property (@(posedge clk_i) disable iff (reset_i)
      (fce && full_duplex_i && $rose(rx_thresh_i)) |=> pause_req_o ##1
      !pause_req_o || $rose(rx_thresh_i))
      else $error("PAUSE request missing at threshold");
   a_backpress_half: // RULE8
   assert property (@(posedge clk_i) disable iff (reset_i)
      (fce && !full_duplex_i && rx_thresh_i) |=> backpressure_o)
      else $error("Back-pressure missing in half duplex");
   a_no_flowctl: // RULE9
   assert property (@(posedge clk_i) disable iff (reset_i)
      !fce |=> !pause_req_o && !backpressure_o)
      else $error("Flow control while disabled");
   a_pad_length: // RULE10
   assert property (@(posedge clk_i) disable iff (reset_i)
      (state_q == S_CRC && pad_en) |-> (cnt_q >= MIN_FRAME - CRC_BYTES))
      else $error("Padded frame shorter than minimum");
   a_crc_four: // RULE12
   assert property (@(posedge clk_i) disable iff (reset_i)
      (state_q == S_CRC && out_free && !flush && crc_idx_q == 2'h3) |=>
      out_last_o && out_valid_o)
      else $error("CRC did not end the frame");
   a_run_start: // RULE13
   assert property (@(posedge clk_i) disable iff (reset_i)
      (state_q == S_STOP && run_en && !flush) |=> tx_running_o)
      else $error("Run enable did not start transmit");
   a_stop_late: // RULE14
   assert property (@(posedge clk_i) disable iff (reset_i)
      (state_q == S_DATA && cnt_q != 7'h00 && !flush &&
       !(fire_in && in_last_i)) |=> (state_q != S_STOP))
      else $error("Stopped in the middle of a frame");
   a_reset_zero: // RULE15
   assert property (@(posedge clk_i)
      reset_i |=> (ctrl_q == 16'h0000) && !tx_running_o)
      else $error("Control not cleared by reset");
endmodule
`default_nettype wire

// ==== dv/mtc_link_sink.sv ====
`timescale 1ns/1ps
`default_nettype none
module mtc_link_sink (
   input  wire logic       clk_i,
   input  wire logic       reset_i,
   input  wire logic [7:0] data_i,
   input  wire logic       valid_i,
   input  wire logic       last_i,
   input  wire logic       stall_i,
   output logic            ready_o
);
   // ---------------------------------------------------------------
   // Byte capture, one frame at a time
   // ---------------------------------------------------------------
   logic [7:0] got_q [0:127];
   logic [7:0] idx_q;
   logic [7:0] len_q;
   int         frames_q;
   wire        fire = valid_i && ready_o;
   // Stall toggles ready so the sender must hold its byte
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         ready_o  <= 1'b0;
         idx_q    <= 8'h00;
         len_q    <= 8'h00;
         frames_q <= 0;
      end else begin
         ready_o <= stall_i ? ~ready_o : 1'b1;
         if (fire) begin
            got_q[idx_q[6:0]] <= data_i;
            idx_q             <= last_i ? 8'h00 : idx_q + 8'h01;
            if (last_i) begin
               len_q    <= idx_q + 8'h01;
               frames_q <= frames_q + 1;
            end
         end
      end
   end
endmodule
`default_nettype wire

// ==== dv/mtc_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin \
   n_compared++; \
   if ((a) !== (b)) begin \
      err_total++; \
      $display("[ERR] %0t got %h want %h", $time, a, b); \
   end \
end
module tb;
   import mtc_pkg::*;
   // ---------------------------------------------------------------
   // Signals
   // ---------------------------------------------------------------
   logic clk_i, reset_i, reg_wr_i, reg_rd_i, in_valid_i, in_last_i;
   logic [7:0] reg_addr_i, in_data_i;
   logic [1:0] reg_be_i;
   logic [15:0] reg_wdata_i, reg_rdata_o, r;
   logic [7:0] out_data_o, ex [0:127];
   logic in_ready_o, out_valid_o, out_last_o, out_ready_i, stall;
   logic full_duplex_i, rx_thresh_i, pause_req_o, backpressure_o;
   logic flush_o, tx_running_o;
   logic [11:0] frame_ptr_o;
   logic [3:0] csum_req_o;
   int err_total, n_compared, nf, n_pause, cyc;
   mtc_top dut (.clk_i(clk_i), .reset_i(reset_i), .reg_wr_i(reg_wr_i),
      .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i), .reg_be_i(reg_be_i),
      .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
      .in_data_i(in_data_i), .in_valid_i(in_valid_i),
      .in_last_i(in_last_i), .in_ready_o(in_ready_o),
      .out_data_o(out_data_o), .out_valid_o(out_valid_o),
      .out_last_o(out_last_o), .out_ready_i(out_ready_i),
      .full_duplex_i(full_duplex_i), .rx_thresh_i(rx_thresh_i),
      .pause_req_o(pause_req_o), .backpressure_o(backpressure_o),
      .flush_o(flush_o), .tx_running_o(tx_running_o),
      .frame_ptr_o(frame_ptr_o), .csum_req_o(csum_req_o));
   mtc_link_sink sink (.clk_i(clk_i), .reset_i(reset_i),
      .data_i(out_data_o), .valid_i(out_valid_o), .last_i(out_last_o),
      .stall_i(stall), .ready_o(out_ready_i));
   initial begin
      clk_i = 1'b0;
      forever #25 clk_i = ~clk_i;
   end
   always @(posedge clk_i) begin
      cyc++;
      if (pause_req_o === 1'b1) n_pause++;
      if (cyc == 20000) begin
         err_total++;
         complete_run();
      end
   end
   // ---------------------------------------------------------------
   // Access tasks
   // ---------------------------------------------------------------
   task automatic wr(input logic [15:0] d, input logic [1:0] be = 2'b11);
      @(negedge clk_i);
      reg_addr_i = TXC_OFFSET;
      reg_wdata_i = d;
      reg_be_i = be;
      reg_wr_i = 1'b1;
      @(negedge clk_i);
      reg_wr_i = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [15:0] d);
      @(negedge clk_i);
      reg_addr_i = a;
      reg_rd_i = 1'b1;
      @(negedge clk_i);
      reg_rd_i = 1'b0;
      d = reg_rdata_o;
   endtask
   // Fixed header fields make the frame look like IPv4
   task automatic send(input int n, input logic [7:0] p);
      for (int i = 0; i < n; i++) begin
         ex[i] = (i == 12) ? ETYPE_IPV4_HI : (i == 13) ? ETYPE_IPV4_LO :
                 (i == 14) ? 8'h45 : (i == 23) ? p : 8'(i + 1);
         @(negedge clk_i);
         in_data_i = ex[i];
         in_valid_i = 1'b1;
         in_last_i = (i == n - 1);
         while (in_ready_o !== 1'b1) @(negedge clk_i);
         @(posedge clk_i);
      end
      @(negedge clk_i);
      in_valid_i = 1'b0;
      in_last_i = 1'b0;
      nf++;
   endtask
   task automatic chk_frame(input int n, input bit pad, input bit crc_on);
      int m;
      logic [31:0] c;
      m = (pad && n < (crc_on ? 60 : 64)) ? (crc_on ? 60 : 64) : n;
      c = CRC_INIT;
      for (int i = 0; i < m; i++) begin
         if (i >= n) ex[i] = 8'h00;
         c = c ^ {24'h0, ex[i]};
         for (int b = 0; b < 8; b++) c = c[0] ? (c >> 1) ^ CRC_POLY : c >> 1;
      end
      c = ~c;
      wait (sink.frames_q == nf);
      @(negedge clk_i);
      `CHK(sink.len_q, 8'(m + (crc_on ? 4 : 0)))
      for (int i = 0; i < m; i++) `CHK(sink.got_q[i], ex[i])
      if (crc_on) for (int k = 0; k < 4; k++) `CHK(sink.got_q[m + k], c[8*k+:8])
      repeat (2) @(negedge clk_i);
   endtask
   task automatic complete_run();
      $display("compared %0d errors %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // ---------------------------------------------------------------
   // Sequence
   // ---------------------------------------------------------------
   initial begin
      {reg_wr_i, reg_rd_i, in_valid_i, in_last_i, stall} = '0;
      {reg_addr_i, in_data_i, reg_be_i, reg_wdata_i} = '0;
      {full_duplex_i, rx_thresh_i, err_total, n_compared, nf} = '0;
      {n_pause, cyc} = '0;
      reset_i = 1'b1;
      repeat (12) @(posedge clk_i);
      @(negedge clk_i);
      reset_i = 1'b0;
      rd(TXC_OFFSET, r);
      `CHK(r, TXC_RESET)
      `CHK({tx_running_o, flush_o, csum_req_o}, 6'h00)
      wr(16'hffee);
      rd(TXC_OFFSET, r);
      `CHK(r, 16'h01ee)
      wr(16'h0000, 2'b01);
      rd(TXC_OFFSET, r);
      `CHK(r, 16'h0100)
      rd(8'h72, r);
      `CHK(r, 16'h0000)
      // Stalling sink on odd passes exercises the output hold
      for (int k = 0; k < 4; k++) begin
         stall = k[0];
         wr(16'h0001 | 16'(k[1]) << PAD_BIT | 16'(k[0]) << CRC_BIT);
         send(5, 8'h00);
         chk_frame(5, k[1], k[0]);
      end
      wr(16'h0007);
      send(60, 8'h00);
      chk_frame(60, 1, 1);
      for (int j = 0; j < 3; j++) begin
         wr(16'h01e3);
         send(30, j == 0 ? PROTO_ICMP : j == 1 ? PROTO_UDP : PROTO_TCP);
         chk_frame(30, 0, 1);
         `CHK(csum_req_o, {j == 0, j == 1, j == 2, 1'b1})
      end
      // Every protocol with its enable off must raise no request
      for (int j = 0; j < 3; j++) begin
         wr(16'h0003);
         send(30, j == 0 ? PROTO_ICMP : j == 1 ? PROTO_UDP : PROTO_TCP);
         chk_frame(30, 0, 1);
         `CHK(csum_req_o, 4'h0)
      end
      for (int i = 0; i < 4; i++) begin
         wr(i[1] ? 16'h0009 : 16'h0001);
         full_duplex_i = i[0];
         n_pause = 0;
         @(negedge clk_i);
         rx_thresh_i = 1'b1;
         repeat (3) @(negedge clk_i);
         `CHK(n_pause, (i == 3) ? 1 : 0)
         `CHK(backpressure_o, 1'(i == 2))
         rx_thresh_i = 1'b0;
         repeat (3) @(negedge clk_i);
      end
      wr(16'h0003);
      fork
         send(24, 8'h00);
         begin
            repeat (10) @(negedge clk_i);
            wr(16'h0002);
         end
      join
      `CHK(tx_running_o, 1'b1)
      chk_frame(24, 0, 1);
      `CHK({tx_running_o, in_ready_o}, 2'b00)
      `CHK(frame_ptr_o, 12'(nf))
      wr(16'h0010);
      // Flush acts one cycle after the write lands
      @(negedge clk_i);
      `CHK({flush_o, frame_ptr_o}, 13'h1000)
      wr(16'h0000);
      @(negedge clk_i);
      `CHK(flush_o, 1'b0)
      wr(16'h0003);
      send(5, 8'h00);
      chk_frame(5, 0, 1);
      `CHK(frame_ptr_o, 12'h001)
      complete_run();
   end
endmodule
`default_nettype wire
